/* logic/pwb_bridge_out.sv */
// Bridge PWM output stage with dead band, auto-shutdown and APB registers
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module pwb_bridge_out
  import pwb_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        SRST_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Timer core and steering
  input  wire logic        PERIOD_START_IN,
  input  wire logic [3:0]  RAW_PWM_IN,
  // Shutdown sources
  input  wire logic        COMP1_IN,
  input  wire logic        COMP2_IN,
  input  wire logic        FAULT_INPUT_N_IN,
  // Bridge pins
  output logic             BRIDGE_OUT_A_OUT,
  output logic             BRIDGE_OUT_B_OUT,
  output logic             BRIDGE_OUT_C_OUT,
  output logic             BRIDGE_OUT_D_OUT,
  output logic             BRIDGE_OE_AC_OUT,
  output logic             BRIDGE_OE_BD_OUT,
  // Status
  output logic             PERIOD_TIMER_FLAG_OUT,
  output logic             SHUTDOWN_STATUS_FLAG_OUT
);

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  // Registers
  logic                 auto_restart_enable_q;
  logic [PWB_DLY_W-1:0] deadband_count_q;
  logic                 shutdown_status_flag_q;
  logic [2:0]           shutdown_source_select_q;
  logic [1:0]           pair_ac_shutdown_level_q;
  logic [1:0]           pair_bd_shutdown_level_q;
  pwb_cfg_type          output_config_select_q;
  logic [1:0]           output_polarity_select_q;
  logic                 period_timer_flag_q;
  logic                 hold_q;
  logic [2:0]           src_meta_q;
  logic [2:0]           src_sync_q;
  logic [3:0]           pin_level_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;

  // Bus decode
  logic wr_en;
  logic setup_ph;
  logic wr_delay;
  logic wr_shutdown;
  logic wr_mode;
  logic wr_status;
  logic mapped;

  assign setup_ph    = PSEL_IN && !PENABLE_IN;
  assign wr_en       = PSEL_IN && PENABLE_IN && PWRITE_IN && pready_q;
  assign wr_delay    = wr_en && PADDR_IN == PWB_OFS_DELAY;
  assign wr_shutdown = wr_en && PADDR_IN == PWB_OFS_SHUTDOWN;
  assign wr_mode     = wr_en && PADDR_IN == PWB_OFS_MODE;
  assign wr_status   = wr_en && PADDR_IN == PWB_OFS_STATUS;
  assign mapped      = PADDR_IN == PWB_OFS_DELAY || PADDR_IN == PWB_OFS_SHUTDOWN ||
                       PADDR_IN == PWB_OFS_MODE  || PADDR_IN == PWB_OFS_STATUS;

  // Shutdown sources, raw and synchronised
  logic [2:0] src_raw;
  logic       cause_raw;
  logic       cause_sync;

  assign src_raw[PWB_SRC_CMP1]  = COMP1_IN;
  assign src_raw[PWB_SRC_CMP2]  = COMP2_IN;
  assign src_raw[PWB_SRC_FAULT] = !FAULT_INPUT_N_IN;
  assign cause_raw  = |(src_raw & shutdown_source_select_q);
  assign cause_sync = |(src_sync_q & shutdown_source_select_q);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      src_meta_q <= 3'h0;
      src_sync_q <= 3'h0;
    end else begin
      src_meta_q <= src_raw;
      src_sync_q <= src_meta_q;
    end
  end

  // Delay and restart register
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      auto_restart_enable_q <= PWB_RST_DELAY[PWB_BIT_RESTART];
      deadband_count_q      <= PWB_RST_DELAY[PWB_DLY_W-1:0];
    end else if (wr_delay) begin
      auto_restart_enable_q <= PWDATA_IN[PWB_BIT_RESTART];
      deadband_count_q      <= PWDATA_IN[PWB_DLY_W-1:0];
    end
  end

  // Shutdown control fields
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      shutdown_source_select_q <= PWB_RST_SHUTDOWN[PWB_POS_SRC+:3];
      pair_ac_shutdown_level_q <= PWB_RST_SHUTDOWN[PWB_POS_AC+:2];
      pair_bd_shutdown_level_q <= PWB_RST_SHUTDOWN[PWB_POS_BD+:2];
    end else if (wr_shutdown) begin
      shutdown_source_select_q <= PWDATA_IN[PWB_POS_SRC+:3];
      pair_ac_shutdown_level_q <= PWDATA_IN[PWB_POS_AC+:2];
      pair_bd_shutdown_level_q <= PWDATA_IN[PWB_POS_BD+:2];
    end
  end

  // Shutdown status flag; hardware set wins over any clear
  logic flag_wr_ok;
  assign flag_wr_ok = wr_shutdown && !cause_sync && !cause_raw;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      shutdown_status_flag_q <= PWB_RST_SHUTDOWN[PWB_BIT_FLAG];
    end else if (cause_sync) begin
      shutdown_status_flag_q <= 1'b1;
    end else if (flag_wr_ok) begin
      shutdown_status_flag_q <= PWDATA_IN[PWB_BIT_FLAG];
    end else if (auto_restart_enable_q) begin
      shutdown_status_flag_q <= 1'b0;
    end
  end

  // Period hold: shutdown stays until a period starts with the flag clear
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      hold_q <= 1'b0;
    end else if (shutdown_status_flag_q || cause_sync) begin
      hold_q <= 1'b1;
    end else if (PERIOD_START_IN) begin
      hold_q <= 1'b0;
    end
  end

  // Mode register
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      output_config_select_q   <= pwb_cfg_type'(PWB_RST_MODE[PWB_POS_CONFIG+:2]);
      output_polarity_select_q <= PWB_RST_MODE[PWB_POS_POLARITY+:2];
    end else if (wr_mode) begin
      output_config_select_q   <= pwb_cfg_type'(PWDATA_IN[PWB_POS_CONFIG+:2]);
      output_polarity_select_q <= PWDATA_IN[PWB_POS_POLARITY+:2];
    end
  end

  // Period timer flag, write one to clear, set wins
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      period_timer_flag_q <= 1'b0;
    end else if (PERIOD_START_IN) begin
      period_timer_flag_q <= 1'b1;
    end else if (wr_status && PWDATA_IN[PWB_BIT_TIMERFLAG]) begin
      period_timer_flag_q <= 1'b0;
    end
  end

  // Dead-band channels A and B
  logic       half_mode;
  logic [1:0] dly_out;
  assign half_mode = output_config_select_q == PWB_CFG_HALF;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_dly
      pwb_delay_if dif ();
      assign dif.raw    = (ch == 0) ? RAW_PWM_IN[0] : (half_mode ? !RAW_PWM_IN[0] : RAW_PWM_IN[1]);
      assign dif.enable = half_mode;
      assign dif.count  = deadband_count_q;
      assign dly_out[ch] = dif.dly_out;
      pwb_deadband u_dly (
        .clk_in  (CLK_IN),
        .srst_in (SRST_IN),
        .dly     (dif.unit)
      );
    end
  endgenerate

  // Normal pin levels after polarity
  logic [3:0] active_lvl;
  assign active_lvl = {RAW_PWM_IN[3], RAW_PWM_IN[2], dly_out[1], dly_out[0]};

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pin_level_q <= 4'h0;
    end else begin
      pin_level_q[0] <= active_lvl[0] ^ output_polarity_select_q[1];
      pin_level_q[2] <= active_lvl[2] ^ output_polarity_select_q[1];
      pin_level_q[1] <= active_lvl[1] ^ output_polarity_select_q[0];
      pin_level_q[3] <= active_lvl[3] ^ output_polarity_select_q[0];
    end
  end

  // Asynchronous pin override
  logic override;
  assign override = cause_raw || shutdown_status_flag_q || hold_q;

  always_comb begin
    if (override) begin
      BRIDGE_OUT_A_OUT = pair_ac_shutdown_level_q == PWB_LVL_HIGH;
      BRIDGE_OUT_C_OUT = pair_ac_shutdown_level_q == PWB_LVL_HIGH;
      BRIDGE_OE_AC_OUT = !pair_ac_shutdown_level_q[1];
      BRIDGE_OUT_B_OUT = pair_bd_shutdown_level_q == PWB_LVL_HIGH;
      BRIDGE_OUT_D_OUT = pair_bd_shutdown_level_q == PWB_LVL_HIGH;
      BRIDGE_OE_BD_OUT = !pair_bd_shutdown_level_q[1];
    end else begin
      BRIDGE_OUT_A_OUT = pin_level_q[0];
      BRIDGE_OUT_C_OUT = pin_level_q[2];
      BRIDGE_OE_AC_OUT = 1'b1;
      BRIDGE_OUT_B_OUT = pin_level_q[1];
      BRIDGE_OUT_D_OUT = pin_level_q[3];
      BRIDGE_OE_BD_OUT = 1'b1;
    end
  end

  // APB read data and answer, prepared in the setup phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (PADDR_IN)
      PWB_OFS_DELAY:    rd_mux = {24'h000000, auto_restart_enable_q, deadband_count_q};
      PWB_OFS_SHUTDOWN: rd_mux = {24'h000000, shutdown_status_flag_q, shutdown_source_select_q,
                                  pair_ac_shutdown_level_q, pair_bd_shutdown_level_q};
      PWB_OFS_MODE:     rd_mux = {28'h0000000, output_config_select_q, output_polarity_select_q};
      PWB_OFS_STATUS:   rd_mux = {28'h0000000, override, period_timer_flag_q, hold_q,
                                  cause_sync};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (setup_ph) begin
        prdata_q  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
        pslverr_q <= !mapped;
      end
    end
  end

  assign PRDATA_OUT               = prdata_q;
  assign PREADY_OUT               = pready_q;
  assign PSLVERR_OUT              = pslverr_q;
  assign PERIOD_TIMER_FLAG_OUT    = period_timer_flag_q;
  assign SHUTDOWN_STATUS_FLAG_OUT = shutdown_status_flag_q;

  // Assertions
  a_cause_sets_flag: assert property (cause_sync |=> shutdown_status_flag_q)
    else $error("Flag not set by shutdown cause");

  a_override_now: assert property (cause_raw |-> override)
    else $error("Pins not overridden while cause present");

  a_flag_no_wclear: assert property (
    (cause_sync && wr_shutdown && !PWDATA_IN[PWB_BIT_FLAG]) |=> shutdown_status_flag_q)
    else $error("Flag cleared by write during shutdown");

  a_auto_restart: assert property (
    (auto_restart_enable_q && !cause_sync && !wr_en && shutdown_status_flag_q)
      |=> !shutdown_status_flag_q)
    else $error("Flag not auto-cleared");

  a_manual_hold: assert property (
    (!auto_restart_enable_q && !wr_en && shutdown_status_flag_q)
      |=> shutdown_status_flag_q)
    else $error("Flag cleared without software");

  a_force_write: assert property (
    (flag_wr_ok && PWDATA_IN[PWB_BIT_FLAG]) |=> shutdown_status_flag_q ##0 override)
    else $error("Writing one did not force shutdown");

  a_period_hold: assert property (
    (hold_q && !PERIOD_START_IN) |=> hold_q)
    else $error("Hold released outside period start");

  a_no_db_full: assert property (
    (!half_mode && RAW_PWM_IN[0] && !output_polarity_select_q[1]) |=> pin_level_q[0])
    else $error("Dead band inserted outside half-bridge");

  a_resume_start: assert property (
    $fell(hold_q) |-> $past(PERIOD_START_IN))
    else $error("Outputs resumed away from a period start");

  a_level_ac: assert property (
    (override && pair_ac_shutdown_level_q == PWB_LVL_LOW)
      |-> (BRIDGE_OE_AC_OUT && !BRIDGE_OUT_A_OUT && !BRIDGE_OUT_C_OUT))
    else $error("Pair A/C not driven low in shutdown");

  a_bd_release: assert property (
    (override && pair_bd_shutdown_level_q[1]) |-> !BRIDGE_OE_BD_OUT)
    else $error("Pair B/D still driven with release level");

  a_wr_ignored: assert property (
    (cause_raw && wr_shutdown && !PWDATA_IN[PWB_BIT_FLAG] && shutdown_status_flag_q)
      |=> shutdown_status_flag_q)
    else $error("Flag write accepted while cause present");

  a_src_decode: assert property (
    (shutdown_source_select_q[PWB_SRC_FAULT] && !FAULT_INPUT_N_IN) |-> cause_raw)
    else $error("Selected fault pin not a shutdown cause");

  a_timer_flag: assert property (PERIOD_START_IN |=> period_timer_flag_q)
    else $error("Timer flag not set at period start");

endmodule : pwb_bridge_out

/* logic/pwb_pkg.sv */
// Package with register map, field layout and constants of the bridge output stage
package pwb_pkg;

  // Register byte offsets
  localparam logic [7:0] PWB_OFS_DELAY    = 8'h00;
  localparam logic [7:0] PWB_OFS_SHUTDOWN = 8'h04;
  localparam logic [7:0] PWB_OFS_MODE     = 8'h08;
  localparam logic [7:0] PWB_OFS_STATUS   = 8'h0C;

  // Reset values
  localparam logic [7:0] PWB_RST_DELAY    = 8'h00;
  localparam logic [7:0] PWB_RST_SHUTDOWN = 8'h00;
  localparam logic [3:0] PWB_RST_MODE     = 4'h0;

  // Field positions
  localparam int PWB_BIT_RESTART   = 7;
  localparam int PWB_BIT_FLAG      = 7;
  localparam int PWB_POS_SRC       = 4;
  localparam int PWB_POS_AC        = 2;
  localparam int PWB_POS_BD        = 0;
  localparam int PWB_POS_CONFIG    = 2;
  localparam int PWB_POS_POLARITY  = 0;
  localparam int PWB_BIT_TIMERFLAG = 2;

  // Widths
  localparam int PWB_DLY_W = 7;

  // Shutdown source select bits
  localparam int PWB_SRC_CMP1  = 0;
  localparam int PWB_SRC_CMP2  = 1;
  localparam int PWB_SRC_FAULT = 2;

  // Output configurations
  typedef enum logic [1:0] {
    PWB_CFG_SINGLE  = 2'h0,
    PWB_CFG_FULLFWD = 2'h1,
    PWB_CFG_HALF    = 2'h2,
    PWB_CFG_FULLREV = 2'h3
  } pwb_cfg_type;

  // Shutdown pin levels
  localparam logic [1:0] PWB_LVL_LOW  = 2'h0;
  localparam logic [1:0] PWB_LVL_HIGH = 2'h1;

  // Instruction cycle timing: 4 oscillator periods at 80 MHz oscillator
  localparam int PWB_TOSC_PER_CYCLE = 4;
  localparam int PWB_CLK_HZ         = 20000000;
  localparam int PWB_DLY_UNIT_CLKS  = 1;

endpackage : pwb_pkg

/* logic/pwb_delay_if.sv */
// Interface between the output stage and one dead-band delay unit
`timescale 1ns/1ps
interface pwb_delay_if;
  import pwb_pkg::*;
  logic                 raw;
  logic                 enable;
  logic [PWB_DLY_W-1:0] count;
  logic                 dly_out;

  modport unit (input raw, input enable, input count, output dly_out);
  modport ctrl (output raw, output enable, output count, input dly_out);
endinterface : pwb_delay_if

/* logic/pwb_deadband.sv */
// Dead-band delay unit for one bridge output
`timescale 1ns/1ps
module pwb_deadband
  import pwb_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_in,
  input  wire logic     srst_in,
  // Delay channel
  pwb_delay_if.unit     dly
);

  logic [PWB_DLY_W-1:0] cnt_q;
  logic                 done;

  // Inactive level passes at once, active level once count cycles have passed
  assign done        = !dly.enable || cnt_q >= dly.count;
  assign dly.dly_out = dly.raw && done;

  always_ff @(posedge clk_in) begin
    if (srst_in || !dly.raw) begin
      cnt_q <= '0;
    end else if (!done) begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  // Counter restarts whenever raw is inactive
  a_fall_fast: assert property (@(posedge clk_in) disable iff (srst_in)
    !dly.raw |=> cnt_q == '0)
    else $error("Delay counter not restarted after raw fell");

  // Output stays inactive on the edge where raw turns active
  a_rise_late: assert property (@(posedge clk_in) disable iff (srst_in)
    (dly.enable && $rose(dly.raw) && dly.count != '0) |-> !dly.dly_out)
    else $error("Delayed output rose before count elapsed");

endmodule : pwb_deadband

/* tb/pwb_switch_model.sv */
// Model of the bridge switch drivers with pull-downs on their gate inputs
`timescale 1ns/1ps
module pwb_switch_model (
  // Pin side
  input  wire logic [3:0] pin_in,
  input  wire logic       oe_ac_in,
  input  wire logic       oe_bd_in,
  // Resolved gate levels, bit0 = A
  output logic [3:0]      gate_out
);
  // Released pins fall to the pull-down level, switch off
  assign gate_out = {oe_bd_in & pin_in[3], oe_ac_in & pin_in[2],
                     oe_bd_in & pin_in[1], oe_ac_in & pin_in[0]};
endmodule : pwb_switch_model

/* tb/pwb_bridge_out_test.sv */
// Self-checking bench of the bridge output stage
`timescale 1ns/1ps
module pwb_bridge_out_test
  import pwb_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst, psel, penable, pwrite, pstart, c1, c2, flt_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pa, pb, pc, pd, oe_ac, oe_bd, tflag, sflag;
  logic [3:0]  raw, pins, gate;
  int          bad_count = 0;
  int          total_checks = 0;

  assign pins = {pd, pc, pb, pa};
  always #25 clk = ~clk;

  pwb_bridge_out u_dut (
    .CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PERIOD_START_IN(pstart),
    .RAW_PWM_IN(raw), .COMP1_IN(c1), .COMP2_IN(c2), .FAULT_INPUT_N_IN(flt_n),
    .BRIDGE_OUT_A_OUT(pa), .BRIDGE_OUT_B_OUT(pb), .BRIDGE_OUT_C_OUT(pc),
    .BRIDGE_OUT_D_OUT(pd), .BRIDGE_OE_AC_OUT(oe_ac), .BRIDGE_OE_BD_OUT(oe_bd),
    .PERIOD_TIMER_FLAG_OUT(tflag), .SHUTDOWN_STATUS_FLAG_OUT(sflag));

  pwb_switch_model u_switch (.pin_in(pins), .oe_ac_in(oe_ac), .oe_bd_in(oe_bd),
                             .gate_out(gate));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      wrap_up();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(w, exp, r);
  endtask : rchk

  task automatic period();
    @(posedge clk);
    pstart <= 1'b1;
    @(posedge clk);
    pstart <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : period

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    logic        hi;
    {psel, penable, pwrite, pstart, c1, c2, raw, paddr, pwdata} = '0;
    flt_n = 1'b1;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rchk("delay", PWB_OFS_DELAY, {24'h0, PWB_RST_DELAY});
    rchk("shutdown", PWB_OFS_SHUTDOWN, {24'h0, PWB_RST_SHUTDOWN});
    rchk("mode", PWB_OFS_MODE, {28'h0, PWB_RST_MODE});
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    wr(PWB_OFS_DELAY, 32'hFF);
    rchk("delay rw", PWB_OFS_DELAY, 32'hFF);
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      wr(PWB_OFS_MODE, {28'h0, PWB_CFG_FULLFWD, p[1:0]});
      repeat (2) @(posedge clk);
      #1 chk("polarity", {28'h0, p[0], p[1], p[0], p[1]}, {28'h0, pins});
    end
    $display("test polarity done");
    wr(PWB_OFS_MODE, {28'h0, PWB_CFG_HALF, 2'h0});
    wr(PWB_OFS_DELAY, 32'h03);
    repeat (6) @(posedge clk);
    raw <= 4'h1;
    repeat (3) @(posedge clk);
    #1 chk("dead band a", 32'h0, {31'h0, pa});
    @(posedge clk);
    #1 chk("a active", 32'h1, {31'h0, pa});
    @(posedge clk);
    raw <= 4'h0;
    @(posedge clk);
    #1 chk("a off", 32'h0, {31'h0, pa});
    repeat (2) @(posedge clk);
    #1 chk("dead band b", 32'h0, {31'h0, pb});
    @(posedge clk);
    #1 chk("b active", 32'h1, {31'h0, pb});
    @(posedge clk);
    raw <= 4'h1;
    repeat (2) @(posedge clk);
    raw <= 4'h0;
    hi = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1 hi |= pa;
    end
    chk("short pulse", 32'h0, {31'h0, hi});
    wr(PWB_OFS_MODE, {28'h0, PWB_CFG_FULLFWD, 2'h0});
    raw <= 4'h1;
    @(posedge clk);
    #1 chk("no dead band", 32'h1, {31'h0, pa});
    raw <= 4'hC;
    @(posedge clk);
    #1 chk("c d follow raw", 32'hC, {28'h0, pins});
    raw <= 4'h0;
    $display("test dead band done");
    wr(PWB_OFS_DELAY, 32'h80);
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        wr(PWB_OFS_SHUTDOWN, {25'h0, s[2:0], 4'h5});
        @(posedge clk);
        c1 <= (k == 0);
        c2 <= (k == 1);
        flt_n <= (k != 2);
        #1 chk("override", {28'h0, {4{s[k]}}}, {28'h0, pins});
        repeat (4) @(posedge clk);
        #1 chk("flag set", {31'h0, s[k]}, {31'h0, sflag});
        c1 <= 1'b0;
        c2 <= 1'b0;
        flt_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk("auto clear", 32'h0, {31'h0, sflag});
        chk("hold", {28'h0, {4{s[k]}}}, {28'h0, pins});
        period();
        chk("resumed", 32'h0, {28'h0, pins});
      end
    end
    $display("test sources done");
    wr(PWB_OFS_SHUTDOWN, 32'h10);
    @(posedge clk);
    c1 <= 1'b1;
    wr(PWB_OFS_SHUTDOWN, 32'h10);
    repeat (4) @(posedge clk);
    #1 chk("level cause", 32'h1, {31'h0, sflag});
    wr(PWB_OFS_DELAY, 32'h00);
    c1 <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("sticky", 32'h1, {31'h0, sflag});
    wr(PWB_OFS_SHUTDOWN, 32'h00);
    @(posedge clk);
    #1 chk("sw clear", 32'h0, {31'h0, sflag});
    period();
    $display("test restart done");
    for (int l = 0; l < 4; l++) begin
      wr(PWB_OFS_SHUTDOWN, {24'h0, 4'h8, l[1:0], ~l[1:0]});
      @(posedge clk);
      #1 chk("forced", 32'h1, {31'h0, sflag});
      chk("oe ac", {31'h0, l < 2}, {31'h0, oe_ac});
      chk("oe bd", {31'h0, l > 1}, {31'h0, oe_bd});
      chk("gates", {28'h0, l == 2, l == 1, l == 2, l == 1}, {28'h0, gate});
      wr(PWB_OFS_SHUTDOWN, 32'h00);
      period();
    end
    $display("test levels done");
    chk("timer flag", 32'h1, {31'h0, tflag});
    wr(PWB_OFS_STATUS, 32'h4);
    rchk("status", PWB_OFS_STATUS, 32'h0);
    $display("test timer flag done");
    wrap_up();
  end
endmodule : pwb_bridge_out_test
